// File: logic/tatw_pkg.sv
// What this block does
// - carry flag clear recirculates address unchanged; set adds one during recirculation.
// - serial address bit gates ones into the field and feeds the register back.
// - one count clear per word zeroes bit counter and address window.
// - exactly eleven address shift pulses per word, one position each.
// - fourteen address toggle pulses per word; all but the word-tail one may flip the address track.
// - every tick advances the 5-bit counter; its top bit alternates the two tracks.
// - low bits zero lets the toggle pulse write the first framing pulse.
// - from the second tick, ticks with top bit zero flip the clock track.
// - second-bit gate lets the next toggle pulse write the second framing pulse.
// - after the fourth tick the arm level lets next tick open the window.
// - inside the window a one flips the address track, a zero leaves it.
// - each address period carries 13 clock pulses plus framing and address data.
// - low bits at 1101 open word tail; next toggle pulse zeroes the counter.
// - address register clear after the index mark, first field all zeros.
// - address shift pulse is tick AND window set AND top bit zero.
// - word tail pulse counts address bits 10 and 9 as two-stage counter.
// - both those bits one sets carry flag, added on next recirculation.
// - word tail pulse comes exactly once, at the end of each word.
// - after address 3777 the clock enable drops and formatting stops.
// - head write drivers active only while the writer gate is set.
// - both tracks recorded NRZI: a one flips the level, a zero holds it.
// - index trail clears counter; after guard, switch sets gate; gate allows clock start.
package tatw_pkg;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_GUARD  = 8'h04;
    localparam logic [7:0] REG_START  = 8'h08;
    localparam logic [7:0] REG_DIV    = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // field positions
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_INIT_BIT  = 1;
    localparam int STAT_GATE_BIT  = 0;
    localparam int STAT_CLKEN_BIT = 1;
    localparam int STAT_DONE_BIT  = 2;
    localparam int STAT_CARRY_BIT = 3;
    localparam int STAT_SEQ_LSB   = 4;
    localparam int STAT_CNT_LSB   = 8;
    localparam int STAT_ADR_LSB   = 16;

    // bit-time counter decode points
    localparam logic [3:0]  LOW_FIRST  = 4'h0;
    localparam logic [3:0]  LOW_SECOND = 4'h1;
    localparam logic [3:0]  LOW_ARM    = 4'h2;
    localparam logic [3:0]  LOW_TAIL   = 4'hd;
    localparam logic [1:0]  TOP_WRAP   = 2'h3;
    localparam logic [10:0] ADR_LAST   = 11'h7ff;

    // timing, least times round up
    localparam int CLK_NS   = 20;
    localparam int GUARD_NS = 40000;
    localparam int START_NS = 60000;
    localparam int TICK_NS  = 2000;
    localparam int GUARD_CYC = (GUARD_NS + CLK_NS - 1) / CLK_NS;
    localparam int START_CYC = (START_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] GUARD_RST = 16'(GUARD_CYC);
    localparam logic [15:0] START_RST = 16'(START_CYC);
    localparam logic [15:0] DIV_RST   = 16'(TICK_CYC);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_RUN, SEQ_DONE} tatw_seq_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } tatw_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tatw_axi_rsp_t;

    typedef struct packed {
        tatw_seq_t   seq;
        logic        run_en;
        logic [15:0] guard_val;
        logic [15:0] start_val;
        logic [15:0] div_val;
        logic [15:0] guard_cnt;
        logic [15:0] start_cnt;
        logic [15:0] div_cnt;
        logic        idx_prev;
        logic        writer_gate;
        logic        clock_enable;
        logic        done;
        logic [4:0]  bit_cnt;
        logic        window;
        logic [10:0] addr;
        logic        carry;
        logic        timing_tgl;
        logic        addr_tgl;
        logic        aw_hold;
        logic [7:0]  aw_addr;
        logic        w_hold;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tatw_state_t;

    localparam tatw_state_t TATW_RST = '{
        seq:       SEQ_IDLE,
        guard_val: GUARD_RST,
        start_val: START_RST,
        div_val:   DIV_RST,
        default:   '0
    };

endpackage

// File: logic/tatw_writer.sv
`timescale 1ns/1ns
`default_nettype none
module tatw_writer (
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire tatw_pkg::tatw_axi_req_t axi_req,
    output var tatw_pkg::tatw_axi_rsp_t  axi_rsp,
    input  wire logic                   index_sensor_level,
    input  wire logic                   write_switch,
    output logic                        clock_track_level,
    output logic                        address_track_level,
    output logic                        head_write_enable
);
    import tatw_pkg::*;

    tatw_state_t st_ff;
    tatw_state_t nxt_st;

    logic        index_mark_lead;
    logic        index_mark_trail;
    logic        wr_fire;
    logic        writer_init_pulse;
    logic        clock_tick;
    logic        phase_top;
    logic [3:0]  low_bits;
    logic        clock_track_pulse;
    logic        address_toggle_pulse;
    logic        first_bit_gate;
    logic        second_bit_gate;
    logic        address_window_arm;
    logic        word_tail_window;
    logic        word_tail_pulse;
    logic        count_clear_pulse;
    logic        address_shift_pulse;
    logic        serial_address_bit;
    logic        data_bit_slot;
    logic        stop_now;
    logic [15:0] div_reload;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] wr_merged;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // index mark edges
    assign index_mark_lead  = index_sensor_level & ~st_ff.idx_prev;
    assign index_mark_trail = ~index_sensor_level & st_ff.idx_prev;

    assign clock_tick = st_ff.clock_enable & (st_ff.div_cnt == 16'h0000);
    assign div_reload = (st_ff.div_val == 16'h0000) ? 16'h0000
                                                    : st_ff.div_val - 16'h0001;

    assign phase_top = st_ff.bit_cnt[4];
    assign low_bits  = st_ff.bit_cnt[3:0];

    assign clock_track_pulse = clock_tick & ~phase_top & (low_bits != LOW_FIRST);
    // toggle pulse only with top bit one
    assign address_toggle_pulse = clock_tick & phase_top;

    assign first_bit_gate     = (low_bits == LOW_FIRST);
    assign second_bit_gate    = (low_bits == LOW_SECOND);
    assign address_window_arm = (low_bits == LOW_ARM) & ~st_ff.window;
    assign word_tail_window   = (low_bits == LOW_TAIL);
    assign word_tail_pulse    = address_toggle_pulse & word_tail_window;
    assign count_clear_pulse  = word_tail_pulse;
    assign address_shift_pulse = clock_tick & st_ff.window & ~phase_top;
    assign serial_address_bit  = st_ff.addr[0] ^ st_ff.carry;
    assign data_bit_slot       = st_ff.window & ~word_tail_window;
    // stop once the last address was written
    assign stop_now = word_tail_pulse & (st_ff.addr == ADR_LAST);

    ////////////////////////////////////////////////////////////////////////
    // register bus decode
    assign wr_fire = st_ff.aw_hold & st_ff.w_hold & ~st_ff.bvalid;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_RUN_BIT] = st_ff.run_en;
        status_word = 32'h0000_0000;
        status_word[STAT_GATE_BIT]  = st_ff.writer_gate;
        status_word[STAT_CLKEN_BIT] = st_ff.clock_enable;
        status_word[STAT_DONE_BIT]  = st_ff.done;
        status_word[STAT_CARRY_BIT] = st_ff.carry;
        status_word[STAT_SEQ_LSB +: 2] = st_ff.seq;
        status_word[STAT_CNT_LSB +: 5] = st_ff.bit_cnt;
        status_word[STAT_ADR_LSB +: 11] = st_ff.addr;
    end

    always_comb begin
        unique case (st_ff.aw_addr)
            REG_CTRL:  wr_merged = merge_bytes(ctrl_word, st_ff.w_data,
                                               st_ff.w_strb);
            REG_GUARD: wr_merged = merge_bytes({16'h0000, st_ff.guard_val},
                                               st_ff.w_data, st_ff.w_strb);
            REG_START: wr_merged = merge_bytes({16'h0000, st_ff.start_val},
                                               st_ff.w_data, st_ff.w_strb);
            REG_DIV:   wr_merged = merge_bytes({16'h0000, st_ff.div_val},
                                               st_ff.w_data, st_ff.w_strb);
            default:   wr_merged = 32'h0000_0000;
        endcase
    end

    // init is a self-clearing command bit
    assign writer_init_pulse = wr_fire & (st_ff.aw_addr == REG_CTRL)
                               & st_ff.w_strb[0] & st_ff.w_data[CTRL_INIT_BIT];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        nxt_st.idx_prev = index_sensor_level;

        // write channel
        if (~st_ff.aw_hold & axi_req.awvalid) begin
            nxt_st.aw_hold = 1'b1;
            nxt_st.aw_addr = axi_req.awaddr[7:0];
        end
        if (~st_ff.w_hold & axi_req.wvalid) begin
            nxt_st.w_hold = 1'b1;
            nxt_st.w_data = axi_req.wdata;
            nxt_st.w_strb = axi_req.wstrb;
        end
        if (st_ff.bvalid & axi_req.bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_fire) begin
            nxt_st.aw_hold = 1'b0;
            nxt_st.w_hold  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = RESP_OKAY;
            unique case (st_ff.aw_addr)
                REG_CTRL:   nxt_st.run_en    = wr_merged[CTRL_RUN_BIT];
                REG_GUARD:  nxt_st.guard_val = wr_merged[15:0];
                REG_START:  nxt_st.start_val = wr_merged[15:0];
                REG_DIV:    nxt_st.div_val   = wr_merged[15:0];
                REG_STATUS: nxt_st.bresp     = RESP_OKAY;
                default:    nxt_st.bresp     = RESP_SLVERR;
            endcase
        end

        // read channel, data registered
        if (st_ff.rvalid & axi_req.rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (~st_ff.rvalid & axi_req.arvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            unique case (axi_req.araddr[7:0])
                REG_CTRL:   nxt_st.rdata = ctrl_word;
                REG_GUARD:  nxt_st.rdata = {16'h0000, st_ff.guard_val};
                REG_START:  nxt_st.rdata = {16'h0000, st_ff.start_val};
                REG_DIV:    nxt_st.rdata = {16'h0000, st_ff.div_val};
                REG_STATUS: nxt_st.rdata = status_word;
                default: begin
                    nxt_st.rdata = 32'h0000_0000;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end

        // divider only runs under clock enable
        if (st_ff.clock_enable) begin
            nxt_st.div_cnt = clock_tick ? div_reload
                                        : st_ff.div_cnt - 16'h0001;
        end else begin
            nxt_st.div_cnt = 16'h0000;
        end

        unique case (st_ff.seq)
            SEQ_IDLE: begin
                if (index_mark_lead & st_ff.run_en) begin
                    nxt_st.guard_cnt = st_ff.guard_val;
                    nxt_st.start_cnt = st_ff.start_val;
                    nxt_st.seq       = SEQ_ARMED;
                end
            end
            SEQ_ARMED: begin
                // gate only after guard and with switch held
                if (st_ff.guard_cnt != 16'h0000) begin
                    nxt_st.guard_cnt = st_ff.guard_cnt - 16'h0001;
                end else if (write_switch) begin
                    nxt_st.writer_gate = 1'b1;
                end
                if (st_ff.start_cnt != 16'h0000) begin
                    nxt_st.start_cnt = st_ff.start_cnt - 16'h0001;
                end else if (st_ff.writer_gate) begin
                    nxt_st.clock_enable = 1'b1;
                    nxt_st.seq          = SEQ_RUN;
                end else begin
                    nxt_st.seq = SEQ_IDLE;
                end
            end
            SEQ_RUN: begin
                if (clock_tick) begin
                    if (phase_top) begin
                        nxt_st.bit_cnt = {1'b0, low_bits + 4'h1};
                    end else begin
                        nxt_st.bit_cnt = {1'b1, low_bits};
                    end
                end
                if (clock_track_pulse) begin
                    nxt_st.timing_tgl = ~st_ff.timing_tgl;
                end
                // window opens on tick after arm
                if (clock_tick & ~phase_top & address_window_arm) begin
                    nxt_st.window = 1'b1;
                end
                if (address_toggle_pulse) begin
                    if (first_bit_gate | second_bit_gate) begin
                        nxt_st.addr_tgl = ~st_ff.addr_tgl;
                    end else if (data_bit_slot & serial_address_bit) begin
                        nxt_st.addr_tgl = ~st_ff.addr_tgl;
                    end
                end
                if (address_shift_pulse) begin
                    nxt_st.addr  = {serial_address_bit, st_ff.addr[10:1]};
                    nxt_st.carry = st_ff.carry & st_ff.addr[0];
                end
                if (count_clear_pulse) begin
                    nxt_st.bit_cnt = 5'h00;
                    nxt_st.window  = 1'b0;
                    // two-stage counter on the top bits
                    nxt_st.addr[10:9] = st_ff.addr[10:9] + 2'h1;
                    // wrap of the top bits arms the carry
                    if (st_ff.addr[10:9] == TOP_WRAP) begin
                        nxt_st.carry = 1'b1;
                    end
                end
                // drop clock enable after last address
                if (stop_now) begin
                    nxt_st.clock_enable = 1'b0;
                    nxt_st.writer_gate  = 1'b0;
                    nxt_st.seq          = SEQ_DONE;
                end
            end
            SEQ_DONE: begin
                nxt_st.clock_enable = 1'b0;
            end
        endcase

        // index trail clears counter and address outside the run state
        if (index_mark_trail & (st_ff.seq != SEQ_RUN)) begin
            nxt_st.bit_cnt = 5'h00;
            nxt_st.window  = 1'b0;
            nxt_st.addr    = 11'h000;
            nxt_st.carry   = 1'b0;
        end

        if (writer_init_pulse) begin
            nxt_st.seq          = SEQ_IDLE;
            nxt_st.writer_gate  = 1'b0;
            nxt_st.clock_enable = 1'b0;
            nxt_st.bit_cnt      = 5'h00;
            nxt_st.window       = 1'b0;
            nxt_st.addr         = 11'h000;
            nxt_st.carry        = 1'b0;
            nxt_st.guard_cnt    = 16'h0000;
            nxt_st.start_cnt    = 16'h0000;
        end
        // done is sticky; a stop in the init cycle still wins
        nxt_st.done = stop_now | (st_ff.done & ~writer_init_pulse);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= TATW_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        axi_rsp.awready = ~st_ff.aw_hold;
        axi_rsp.wready  = ~st_ff.w_hold;
        axi_rsp.bvalid  = st_ff.bvalid;
        axi_rsp.bresp   = st_ff.bresp;
        axi_rsp.arready = ~st_ff.rvalid;
        axi_rsp.rvalid  = st_ff.rvalid;
        axi_rsp.rdata   = st_ff.rdata;
        axi_rsp.rresp   = st_ff.rresp;
    end

    // track levels are the NRZI flux state
    assign clock_track_level   = st_ff.timing_tgl;
    assign address_track_level = st_ff.addr_tgl;
    // drivers follow the writer gate only
    assign head_write_enable   = st_ff.writer_gate;

endmodule
`default_nettype wire

// File: testbench/tatw_head_model.sv
`timescale 1ns/1ns
`default_nettype none
module tatw_head_model (
    input  wire logic  clk_sys,
    input  wire logic  srst,
    input  wire logic  mark_req,
    input  wire logic  switch_req,
    input  wire logic  clock_track_level,
    input  wire logic  address_track_level,
    output logic       index_sensor_level,
    output logic       write_switch,
    output logic       word_stb,
    output logic [10:0] word_addr,
    output logic       frame_err
);
    localparam int MARK_W = 3;
    logic [3:0]  mark_cnt;
    logic        ct_prev;
    logic        at_prev;
    logic [3:0]  n_clk;
    logic [1:0]  n_adr;
    logic [9:0]  bits;

    // photocell lit for the mark only
    assign index_sensor_level = (mark_cnt != 4'h0);
    assign write_switch       = switch_req;

    // flips decoded per slot between clock pulses
    always_ff @(posedge clk_sys) begin
        word_stb <= 1'b0;
        ct_prev  <= clock_track_level;
        at_prev  <= address_track_level;
        if (srst)
            mark_cnt <= 4'h0;
        else if (mark_req)
            mark_cnt <= 4'(MARK_W);
        else if (mark_cnt != 4'h0)
            mark_cnt <= mark_cnt - 4'h1;
        if (srst) begin
            n_clk     <= '0;
            n_adr     <= '0;
            bits      <= '0;
            frame_err <= 1'b0;
        end else if (clock_track_level != ct_prev) begin
            n_adr <= '0;
            // slots 0 and 1 must hold one framing flip
            if (n_clk < 4'd2)
                frame_err <= frame_err | (n_adr != 2'd1);
            else
                frame_err <= frame_err | n_adr[1];
            if (n_clk >= 4'd2 && n_clk < 4'd12)
                bits[4'(n_clk - 4'd2)] <= n_adr[0];
            if (n_clk == 4'd12) begin
                word_addr <= {n_adr[0], bits};
                word_stb  <= 1'b1;
                n_clk     <= '0;
            end else begin
                n_clk <= n_clk + 4'd1;
            end
        end else if (address_track_level != at_prev && n_adr != 2'd3) begin
            n_adr <= n_adr + 2'd1;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tatw_writer_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tatw_writer_chk (
    input wire logic                    clk_sys,
    input wire logic                    srst,
    input wire tatw_pkg::tatw_axi_req_t axi_req,
    input wire tatw_pkg::tatw_axi_rsp_t axi_rsp,
    input wire logic                    index_sensor_level,
    input wire logic                    write_switch,
    input wire logic                    clock_track_level,
    input wire logic                    address_track_level,
    input wire logic                    head_write_enable
);
    import tatw_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_track_gated: assert property ((!$stable(clock_track_level)
        || !$stable(address_track_level)) |-> $past(head_write_enable))
        else $error("track flipped without writer gate");
    a_one_track: assert property (!$stable(clock_track_level)
        |-> $stable(address_track_level))
        else $error("both tracks flipped in one cycle");
    a_clk_alternate: assert property (!$stable(clock_track_level)
        |=> $stable(clock_track_level))
        else $error("clock track flipped on adjacent ticks");
    a_adr_alternate: assert property (!$stable(address_track_level)
        |=> $stable(address_track_level))
        else $error("address track flipped on adjacent ticks");
    a_gate_switch: assert property ($rose(head_write_enable)
        |-> $past(write_switch))
        else $error("writer gate set without switch");
    a_ar_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read accepted while answer pending");
    a_rd_latency: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid)
        else $error("read answer late");
    a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped early");
    a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped early");
    a_wr_latency: assert property (axi_req.awvalid && axi_rsp.awready
        && axi_req.wvalid && axi_rsp.wready && !axi_rsp.bvalid
        |-> ##[1:2] axi_rsp.bvalid)
        else $error("write answer late");

    c_gate_up: cover property ($rose(head_write_enable));
    c_gate_down: cover property ($fell(head_write_enable));
    c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
    c_adr_flip: cover property (!$stable(address_track_level));
endmodule

bind tatw_writer tatw_writer_chk i_chk (
    .clk_sys(clk_sys), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .index_sensor_level(index_sensor_level), .write_switch(write_switch),
    .clock_track_level(clock_track_level),
    .address_track_level(address_track_level),
    .head_write_enable(head_write_enable));
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import tatw_pkg::*;
    logic          clk_sys, srst, idx, sw, ct, at, hwe;
    logic          mark_req, switch_req, word_stb, frame_err;
    logic [10:0]   word_addr;
    tatw_axi_req_t axi_req;
    tatw_axi_rsp_t axi_rsp;
    int            n_errors, n_tests, n_words, t;
    logic [31:0]   d, v;
    logic [1:0]    r;

    tatw_writer i_tatw_writer (.clk_sys(clk_sys), .srst(srst),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .index_sensor_level(idx),
        .write_switch(sw), .clock_track_level(ct),
        .address_track_level(at), .head_write_enable(hwe));
    tatw_head_model i_tatw_head_model (.clk_sys(clk_sys), .srst(srst),
        .mark_req(mark_req), .switch_req(switch_req),
        .clock_track_level(ct), .address_track_level(at),
        .index_sensor_level(idx), .write_switch(sw), .word_stb(word_stb),
        .word_addr(word_addr), .frame_err(frame_err));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // handshakes judged on the value held into the rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] wd,
                       output logic [1:0] rs);
        logic ta, tw, tb;
        @(posedge clk_sys);
        axi_req.awaddr <= 32'(a);
        axi_req.wdata <= wd;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = axi_req.awvalid & axi_rsp.awready;
            tw = axi_req.wvalid & axi_rsp.wready;
            tb = axi_rsp.bvalid;
            rs = axi_rsp.bresp;
            @(posedge clk_sys);
            if (ta) axi_req.awvalid <= 1'b0;
            if (tw) axi_req.wvalid <= 1'b0;
        end while (tb !== 1'b1);
        axi_req.bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] rd,
                       output logic [1:0] rs);
        logic ta, tb;
        @(posedge clk_sys);
        axi_req.araddr <= 32'(a);
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = axi_req.arvalid & axi_rsp.arready;
            tb = axi_rsp.rvalid;
            rd = axi_rsp.rdata;
            rs = axi_rsp.rresp;
            @(posedge clk_sys);
            if (ta) axi_req.arvalid <= 1'b0;
        end while (tb !== 1'b1);
        axi_req.rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        axr(a, d, r);
        chk(d, e);
        chk(32'(r), 32'(er));
    endtask

    task automatic mark();
        @(posedge clk_sys);
        mark_req <= 1'b1;
        @(posedge clk_sys);
        mark_req <= 1'b0;
    endtask
    ////////////////////////////////////////
    // model: word n carries bits 10:9 = n mod 4, low bits = n / 4
    always @(posedge clk_sys) begin
        if (srst === 1'b0 && word_stb === 1'b1) begin
            chk(32'(word_addr), 32'((n_words % 4) * 512 + n_words / 4));
            chk(32'(frame_err), 32'h0);
            n_words++;
        end
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        conclude();
    end

    initial begin
        axi_req = '0;
        srst = 1'b1;
        mark_req = 1'b0;
        switch_req = 1'b0;
        void'($urandom(32'heb5d983b));
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        rchk(REG_CTRL, 32'h0, RESP_OKAY);
        rchk(REG_GUARD, 32'(GUARD_RST), RESP_OKAY);
        rchk(REG_START, 32'(START_RST), RESP_OKAY);
        rchk(REG_DIV, 32'(DIV_RST), RESP_OKAY);
        rchk(REG_STATUS, 32'h0, RESP_OKAY);
        v = $urandom;
        axw(REG_GUARD, v, r);
        rchk(REG_GUARD, {16'h0, v[15:0]}, RESP_OKAY);
        axw(8'h14, v, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rchk(8'h14, 32'h0, RESP_SLVERR);
        axw(REG_STATUS, 32'hffffffff, r);
        rchk(REG_STATUS, 32'h0, RESP_OKAY);
        axw(REG_GUARD, 32'h4, r);
        axw(REG_START, 32'h8, r);
        axw(REG_DIV, 32'h1, r);
        axw(REG_CTRL, 32'h1, r);
        $display("test registers done");
        // switch released: gate must stay shut
        mark();
        repeat (30) @(negedge clk_sys);
        chk(32'(hwe), 32'h0);
        rchk(REG_STATUS, 32'h0, RESP_OKAY);
        $display("test no switch done");
        switch_req <= 1'b1;
        mark();
        for (t = 0; t < 40 && hwe !== 1'b1; t++) @(negedge clk_sys);
        chk(32'(hwe), 32'h1);
        for (t = 0; t < 70000 && hwe !== 1'b0; t++) @(negedge clk_sys);
        repeat (100) @(posedge clk_sys);
        chk(32'(n_words), 32'd2048);
        axr(REG_STATUS, d, r);
        chk(d & 32'h37, 32'h34);
        $display("test format run done");
        // init command clears sequencer, address and done flag
        axw(REG_CTRL, 32'h3, r);
        rchk(REG_STATUS, 32'h0, RESP_OKAY);
        rchk(REG_CTRL, 32'h1, RESP_OKAY);
        $display("test init done");
        conclude();
    end
endmodule
`default_nettype wire
